// ===== verilog/dsp_mult_regs.vh
// register map, field positions, reset values and modes of the multiplier
// stage; definitions only, included by the stage module
`ifndef DSP_MULT_REGS_VH
`define DSP_MULT_REGS_VH

// byte offsets on the register bus
`define CTRL_OFS 8'h00
`define SEL_OFS 8'h04
`define STAT_OFS 8'h08

// control register fields
`define CTRL_MODE_LO 0
`define CTRL_SRC_A 2
`define CTRL_SRC_B 3
`define CTRL_INREG_A 4
`define CTRL_INREG_B 5
`define CTRL_PIPE 6
`define CTRL_SIGNREG 7
`define CTRL_SHARED 8
`define CTRL_WIDTH 9
`define CTRL_RST 9'h0f1

// select register fields, two bits each, pick one of four lines
`define SEL_A_LO 0
`define SEL_B_LO 2
`define SEL_P_LO 4
`define SEL_S_LO 6
`define SEL_WIDTH 8
`define SEL_RST 8'h00

// status register fields
`define STAT_MODE_LO 0
`define STAT_REFUSED 2
`define STAT_OVERSIZE 3
`define STAT_OVR_STICKY 4
`define STAT_SIGNED 5

// arrangement codes
`define MODE_9 2'h0
`define MODE_18 2'h1
`define MODE_36 2'h2

`endif

// ===== verilog/dsp_mult_stage.v
// multiplier stage: operand register banks with parallel or chained load,
// eight 9x9 / four 18x18 / one 36x36 multiplier, sign controls, pipeline
// register and an APB register file
// assumes fabric inputs, enables and clears are synchronous to clk_sys
`include "dsp_mult_regs.vh"

module dsp_mult_stage (
   input wire clk_sys,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [3:0] ena,
   input wire [3:0] aclr,
   input wire [71:0] dataA,
   input wire [71:0] dataB,
   input wire signA,
   input wire signB,
   input wire [17:0] chainInFirst,
   input wire [17:0] chainInSecond,
   output reg [17:0] chainOutFirst,
   output reg [17:0] chainOutSecond,
   output reg [143:0] product,
   output reg productSigned,
   output reg signOutA,
   output reg signOutB
);

   // 18x18 lane with per-operand sign extension; 36 bits hold it exactly
   function [35:0] mul18;
      input [17:0] a;
      input [17:0] b;
      input sa;
      input sb;
      reg signed [18:0] x;
      reg signed [18:0] y;
      reg signed [37:0] p;
      begin
         x = {sa & a[17], a};
         y = {sb & b[17], b};
         p = x * y;
         mul18 = p[35:0];
      end
   endfunction

   // 9x9 lane, 18-bit full-precision result
   function [17:0] mul9;
      input [8:0] a;
      input [8:0] b;
      input sa;
      input sb;
      reg signed [9:0] x;
      reg signed [9:0] y;
      reg signed [19:0] p;
      begin
         x = {sa & a[8], a};
         y = {sb & b[8], b};
         p = x * y;
         mul9 = p[17:0];
      end
   endfunction

   // operand width check for the large arrangement with unequal signs
   function tooWide;
      input [35:0] v;
      input s;
      begin
         tooWide = s ? (v[35] ^ v[34]) : v[35];
      end
   endfunction

   reg [`CTRL_WIDTH-1:0] ctrl_reg;
   reg [`SEL_WIDTH-1:0] sel_reg;
   reg ovrSticky_reg;
   reg [71:0] opA_reg;
   reg [71:0] opB_reg;
   reg sgnA_reg;
   reg sgnB_reg;
   reg [143:0] pipe_reg;
   reg pipeSA_reg;
   reg pipeSB_reg;
   reg [143:0] raw;
   reg [143:0] combined;
   reg [71:0] sum36;
   reg [17:0] la;
   reg [17:0] lb;
   reg lsa;
   reg lsb;
   integer i;

   wire [1:0] mode = ctrl_reg[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
   wire mode36 = (mode == `MODE_36);
   wire mode9 = (mode == `MODE_9);
   // chained loading refused in the large arrangement
   wire shA = ctrl_reg[`CTRL_SRC_A] & ~mode36;
   wire shB = ctrl_reg[`CTRL_SRC_B] & ~mode36;
   wire useRegA = ctrl_reg[`CTRL_INREG_A] | shA;
   wire useRegB = ctrl_reg[`CTRL_INREG_B] | shB;
   wire pipeOn = ctrl_reg[`CTRL_PIPE] | mode36;
   wire shared = ctrl_reg[`CTRL_SHARED];

   // per-group enable and clear picked from the four block lines
   wire [1:0] selA = sel_reg[`SEL_A_LO+1:`SEL_A_LO];
   wire [1:0] selB = sel_reg[`SEL_B_LO+1:`SEL_B_LO];
   wire [1:0] selP = sel_reg[`SEL_P_LO+1:`SEL_P_LO];
   wire [1:0] selS = sel_reg[`SEL_S_LO+1:`SEL_S_LO];
   wire enA = ena[selA];
   wire clrA = aclr[selA];
   wire enB = ena[selB];
   wire clrB = aclr[selB];
   wire enP = ena[selP];
   wire clrP = aclr[selP];
   wire enS = ena[selS];
   wire clrS = aclr[selS];

   // one shared control drives both operands when selected
   wire sgnInA = signA;
   wire sgnInB = shared ? signA : signB;
   wire sA = ctrl_reg[`CTRL_SIGNREG] ? sgnA_reg : sgnInA;
   wire sB = ctrl_reg[`CTRL_SIGNREG] ? sgnB_reg : sgnInB;
   wire [71:0] opA = useRegA ? opA_reg : dataA;
   wire [71:0] opB = useRegB ? opB_reg : dataB;

   // 36-bit operands beyond the 35-bit reach when signs differ
   wire oversize = mode36 & (sA != sB) &
      (tooWide(opA[35:0], sA) | tooWide(opB[35:0], sB));

   // operand banks: parallel from fabric or chained in lane steps
   always @(posedge clk_sys) begin
      if (!nrst || clrA) begin
         opA_reg <= 72'h0;
      end else if (enA) begin
         if (!shA) begin
            opA_reg <= dataA;
         end else if (mode9) begin
            opA_reg <= {opA_reg[62:0], chainInFirst[17:9]};
         end else begin
            opA_reg <= {opA_reg[53:0], chainInFirst};
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!nrst || clrB) begin
         opB_reg <= 72'h0;
      end else if (enB) begin
         if (!shB) begin
            opB_reg <= dataB;
         end else if (mode9) begin
            opB_reg <= {opB_reg[62:0], chainInSecond[17:9]};
         end else begin
            opB_reg <= {opB_reg[53:0], chainInSecond};
         end
      end
   end

   // chain taps mirror the bank's top lane as it stands after this edge,
   // so a tap holds while its enable is low unless its clear is high; 9x9 uses bits 17:9
   always @(posedge clk_sys) begin
      if (!nrst) begin
         chainOutFirst <= 18'h0;
         chainOutSecond <= 18'h0;
      end else begin
         chainOutFirst <= clrA ? 18'h0 : !enA ? opA_reg[71:54] :
            !shA ? dataA[71:54] : mode9 ? opA_reg[62:45] : opA_reg[53:36];
         chainOutSecond <= clrB ? 18'h0 : !enB ? opB_reg[71:54] :
            !shB ? dataB[71:54] : mode9 ? opB_reg[62:45] : opB_reg[53:36];
      end
   end

   // optional sign register keeps sign aligned with the operand banks
   always @(posedge clk_sys) begin
      if (!nrst || clrS) begin
         sgnA_reg <= 1'b0;
         sgnB_reg <= 1'b0;
      end else if (enS) begin
         sgnA_reg <= sgnInA;
         sgnB_reg <= sgnInB;
      end
   end

   // lanes: the large case reuses the four medium lanes as partials
   always @* begin
      raw = 144'h0;
      la = 18'h0;
      lb = 18'h0;
      lsa = 1'b0;
      lsb = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         if (mode9) begin
            raw[18*i +: 18] = mul9(opA[9*i +: 9], opB[9*i +: 9], sA, sB);
         end
      end
      for (i = 0; i < 4; i = i + 1) begin
         if (mode36) begin
            // lane 0 lo*lo, 1 lo*hi, 2 hi*lo, 3 hi*hi; low halves unsigned
            la = i[1] ? opA[35:18] : opA[17:0];
            lb = i[0] ? opB[35:18] : opB[17:0];
            lsa = i[1] & sA;
            lsb = i[0] & sB;
            raw[36*i +: 36] = mul18(la, lb, lsa, lsb);
         end else if (!mode9) begin
            raw[36*i +: 36] = mul18(opA[18*i +: 18], opB[18*i +: 18],
               sA, sB);
         end
      end
   end

   // post-multiply register; mandatory internal stage for the large case
   always @(posedge clk_sys) begin
      if (!nrst || clrP) begin
         pipe_reg <= 144'h0;
         pipeSA_reg <= 1'b0;
         pipeSB_reg <= 1'b0;
      end else if (enP) begin
         pipe_reg <= raw;
         pipeSA_reg <= sA;
         pipeSB_reg <= sB;
      end
   end

   wire [143:0] stage = pipeOn ? pipe_reg : raw;
   wire stSA = pipeOn ? pipeSA_reg : sA;
   wire stSB = pipeOn ? pipeSB_reg : sB;

   // shift-add of the partials into one 72-bit result, no truncation
   always @* begin
      sum36 = {36'h0, stage[35:0]} +
         {{18{stSB & stage[71]}}, stage[71:36], 18'h0} +
         {{18{stSA & stage[107]}}, stage[107:72], 18'h0} +
         {stage[143:108], 36'h0};
      combined = mode36 ? {72'h0, sum36} : stage;
   end

   // output flops toward the adder stage
   always @(posedge clk_sys) begin
      if (!nrst || clrP) begin
         product <= 144'h0;
         productSigned <= 1'b0;
         signOutA <= 1'b0;
         signOutB <= 1'b0;
      end else begin
         product <= combined;
         productSigned <= stSA | stSB;
         signOutA <= stSA;
         signOutB <= stSB;
      end
   end

   // apb slave: answers in the first access cycle, write lands there too
   wire setup = psel & ~penable;
   wire wrDone = psel & penable & pready & pwrite;
   wire hit = (paddr == `CTRL_OFS) | (paddr == `SEL_OFS) |
      (paddr == `STAT_OFS);

   always @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl_reg <= `CTRL_RST;
         sel_reg <= `SEL_RST;
         ovrSticky_reg <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         if (wrDone && paddr == `CTRL_OFS) begin
            ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
         end
         if (wrDone && paddr == `SEL_OFS) begin
            sel_reg <= pwdata[`SEL_WIDTH-1:0];
         end
         // a new oversize event beats a write-one clear
         if (oversize) begin
            ovrSticky_reg <= 1'b1;
         end else if (wrDone && paddr == `STAT_OFS &&
               pwdata[`STAT_OVR_STICKY]) begin
            ovrSticky_reg <= 1'b0;
         end
         if (setup && !pwrite) begin
            case (paddr)
               `CTRL_OFS: prdata <= {23'h0, ctrl_reg};
               `SEL_OFS: prdata <= {24'h0, sel_reg};
               `STAT_OFS: prdata <= {26'h0, stSA | stSB, ovrSticky_reg,
                  oversize, mode36 & (ctrl_reg[`CTRL_SRC_A] |
                  ctrl_reg[`CTRL_SRC_B]), mode};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

endmodule // dsp_mult_stage

// ===== verif/dsp_mult_stage_props.sv
// checker: bus answer timing, sign union, clear and chain hold relations
// assumes binding to dsp_mult_stage, all signals in the clk_sys domain
module dsp_mult_stage_props (
   input wire clk_sys,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [3:0] ena,
   input wire [3:0] aclr,
   input wire [17:0] chainOutFirst,
   input wire [143:0] product,
   input wire productSigned,
   input wire signOutA,
   input wire signOutB
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // setup phase and the three decoded offsets
   wire setup = psel && !penable;
   wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
   answer_next_a: assert property (setup |=> pready)
      else $error("no answer after setup");
   answer_once_a: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   answer_cause_a: assert property (pready |-> $past(setup))
      else $error("answer without setup");
   // read data is only zeroed for reads; a refused write keeps old prdata
   refuse_addr_a: assert property (setup && !mapped |=>
      pslverr && (prdata == 0 || $past(pwrite)))
      else $error("unmapped access not refused");
   accept_addr_a: assert property (setup && mapped |=> !pslverr)
      else $error("mapped access refused");
   sign_union_a:
      assert property (productSigned == (signOutA | signOutB))
      else $error("product sign not the union");
   clear_zero_a:
      assert property ((aclr == 4'hf) [*4] |=>
         product == 0 && chainOutFirst == 0)
      else $error("clear left data");
   chain_hold_a:
      assert property (ena == 0 && aclr == 0 |=> $stable(chainOutFirst))
      else $error("chain moved without enable");
   cover property (pslverr);
   cover property (productSigned);
   cover property (aclr == 4'hf ##1 product == 0);
endmodule // dsp_mult_stage_props

bind dsp_mult_stage dsp_mult_stage_props props (.clk_sys(clk_sys),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ena(ena),
   .aclr(aclr), .chainOutFirst(chainOutFirst), .product(product),
   .productSigned(productSigned), .signOutA(signOutA), .signOutB(signOutB));

// ===== verif/chain_feed.sv
// model of the previous block in the chain, feeding both chain inputs
// assumes the bench supplies the values that block would shift out
module chain_feed (
   input wire clk_sys,
   input wire shiftEn,
   input wire [17:0] feedFirst,
   input wire [17:0] feedSecond,
   output logic [17:0] chainInFirst = 18'h0,
   output logic [17:0] chainInSecond = 18'h0
);
   timeunit 1ns;
   timeprecision 100ps;
   // the previous block's top operand register, stepped by its enable
   always @(posedge clk_sys) begin
      if (shiftEn) begin
         chainInFirst <= feedFirst;
         chainInSecond <= feedSecond;
      end
   end
endmodule // chain_feed

// ===== verif/dsp_multiplier_stage_bench.sv
// bench: register reads, every arrangement, all four sign cases in the medium one, chain and clear
// assumes the design answers an apb setup in the next cycle
module dsp_multiplier_stage_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic signA = 0, signB = 0, shiftEn = 0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0] ena = 4'h0, aclr = 4'h0;
   logic [71:0] dataA = 72'h0, dataB = 72'h0, e72;
   logic [17:0] feedFirst = 18'h0, chainInFirst, chainInSecond;
   logic [17:0] chainOutFirst, chainOutSecond;
   logic [143:0] product;
   logic productSigned, signOutA, signOutB;
   logic [35:0] ta[3] = '{36'hfffffffff, 36'h800000000, 36'h7ffffffff};
   logic [35:0] tb[3] = '{36'hfffffffff, 36'h800000001, 36'h800000000};
   int nFail = 0, totalChecks = 0;

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   chain_feed feed (.clk_sys(clk_sys), .shiftEn(shiftEn),
      .feedFirst(feedFirst), .feedSecond(feedFirst),
      .chainInFirst(chainInFirst), .chainInSecond(chainInSecond));

   dsp_mult_stage DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ena(ena),
      .aclr(aclr), .dataA(dataA), .dataB(dataB), .signA(signA),
      .signB(signB), .chainInFirst(chainInFirst),
      .chainInSecond(chainInSecond), .chainOutFirst(chainOutFirst),
      .chainOutSecond(chainOutSecond), .product(product),
      .productSigned(productSigned), .signOutA(signOutA),
      .signOutB(signOutB));

   // comparison helpers, one per kind of result
   task automatic fail(input string m);
      nFail++;
      $display("Error at %0t: %s", $time, m);
   endtask
   task automatic chkReg(input logic [31:0] g, input logic [31:0] x);
      totalChecks++;
      if (g !== x) fail($sformatf("reg %h want %h", g, x));
   endtask
   task automatic chkData(input logic [143:0] g, input logic [143:0] x);
      totalChecks++;
      if (g !== x) fail($sformatf("data %h want %h", g, x));
   endtask

   // one apb transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // exact product of sign-extended operands, wraps to 72 bits on purpose
   function automatic logic [71:0] mulx(logic [35:0] a, logic [35:0] b,
      logic sa, logic sb, int w);
      logic [71:0] x, y;
      x = a;
      y = b;
      if (sa && a[w-1]) x = x | ({72{1'b1}} << w);
      if (sb && b[w-1]) y = y | ({72{1'b1}} << w);
      return x * y;
   endfunction

   task automatic settle;
      repeat (5) @(posedge clk_sys);
   endtask

   task automatic closeOut;
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // watchdog: the tests need about 130 cycles
   initial begin
      repeat (3000) @(posedge clk_sys);
      fail("watchdog expired");
      closeOut;
   end

   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1;
      apb(0, 8'h00, 0);
      chkReg(q, 32'h0f1);
      apb(0, 8'h04, 0);
      chkReg(q, 32'h0);
      apb(0, 8'h0c, 0);
      chkReg({31'h0, err}, 32'h1);
      chkReg(q, 32'h0);
      $display("registers done");
      ena <= 4'h1;
      for (int s = 0; s < 4; s++) begin
         signA <= s[1];
         signB <= s[0];
         dataA <= {4{18'h20001}};
         dataB <= {4{18'h3fffe}};
         settle;
         e72 = mulx(36'h20001, 36'h3fffe, s[1], s[0], 18);
         chkData(product, {4{e72[35:0]}});
         chkReg({productSigned, signOutA, signOutB}, {|s, s[1:0]});
      end
      $display("medium done");
      apb(1, 8'h00, 32'h0f0);
      signA <= 1;
      signB <= 0;
      dataA <= {8{9'h101}};
      dataB <= {8{9'h1ff}};
      settle;
      e72 = mulx(36'h101, 36'h1ff, 1, 0, 9);
      chkData(product, {8{e72[17:0]}});
      $display("small done");
      apb(1, 8'h00, 32'h0f2);
      for (int s = 0; s < 3; s++) begin
         signA <= s == 1;
         signB <= s > 0;
         dataA <= {36'h0, ta[s]};
         dataB <= {36'h0, tb[s]};
         settle;
         e72 = mulx(ta[s], tb[s], s == 1, s > 0, 36);
         chkData(product, {72'h0, e72});
      end
      apb(1, 8'h00, 32'h0f6);
      settle;
      chkData(product, {72'h0, e72});
      apb(0, 8'h08, 0);
      // signed -2^35 operand against an unsigned one is past 35 bits
      chkReg({26'h0, q[5:0]}, 32'h3e);
      apb(1, 8'h00, 32'h1f2);
      signA <= 1;
      signB <= 0;
      dataA <= {36'h0, ta[1]};
      dataB <= {36'h0, tb[1]};
      settle;
      e72 = mulx(ta[1], tb[1], 1, 1, 36);
      chkData(product, {72'h0, e72});
      apb(1, 8'h08, 32'h10);
      apb(0, 8'h08, 0);
      chkReg({27'h0, q[4:0]}, 32'h02);
      $display("large done");
      apb(1, 8'h00, 32'h0f5);
      signA <= 0;
      signB <= 0;
      feedFirst <= 18'h00123;
      shiftEn <= 1;
      dataB <= {4{18'h00005}};
      repeat (10) @(posedge clk_sys);
      chkData(chainOutFirst, 18'h00123);
      chkData(product, {4{36'h0000005af}});
      chkData(chainOutSecond, 18'h00005);
      // move bank A onto the idle line 1: the chain must freeze
      apb(1, 8'h04, 32'h01);
      feedFirst <= 18'h00456;
      repeat (6) @(posedge clk_sys);
      chkData(chainOutFirst, 18'h00123);
      apb(0, 8'h04, 0);
      chkReg(q, 32'h01);
      $display("chain done");
      aclr <= 4'hf;
      repeat (6) @(posedge clk_sys);
      chkData(product, 0);
      chkData(chainOutFirst, 0);
      $display("clear done");
      closeOut;
   end
endmodule // dsp_multiplier_stage_bench
